// ---- rtl/mpu_decode_multiplier_bridge.sv ----
/*
  Processor bus bridge: address decode, selects, display latches and multiplier byte path.
  Assumes an 8-bit bus master that presents address, direction and valid before the
  phase clock E rises and holds write data until E falls.
*/
// Overview of operation
// - Nonvolatile store 5120-6143, working RAM 8192-16383 and 16384-24575, ROM above.
// - Talker/listener adapter at 4352-4359, parallel I/O adapter at 4608-4623.
// - Display latches at 4096-4097 and 4160-4161, plus multiplier support selects.
// - Address 0: write loads multiplicand, read returns high product byte.
// - Address 2: write loads multiplier, read returns high byte of the lower product word.
// - Program store is two ROMs, 24K and 16K, each with its own select.
// - Working storage is two 8K static RAMs, no refresh.
// - A 1K nonvolatile store holds calibration constants.
// - Multiply two 16-bit operands to 32 bits within 75 ns.
// - Half select low gives upper product word, high gives lower word.
// - Product port drives only while its active-low enable is low.
// - Multiplicand and multiplier load on separate strobes; upper and lower product share one strobe.
// - Low byte write loads holding latch plus bus byte into multiplicand.
// - The multiplier operand loads by the same two-step sequence.
// - After both operands load, upper and lower product strobes fire.
// - Every product read drives the product port enable low.
// - A byte latch keeps the low eight bits of the product word last read for a second read.
// - Address bits 2..0 select one of the adapter's eight registers.
// - Adapter accepts access only while its active-low chip enable is low.
// - Adapter reset stays low about 690 ms after power-up.
// - Direction high means read, low means write; strobes follow it.
// - Accesses are timed by quadrature 2 MHz phase clocks from the system clock.
`timescale 1ns/1ps
`include "mpu_bridge_consts.svh"
module mpu_decode_multiplier_bridge #(
  parameter int unsigned ADAPTER_RST_CYCLES = `ADAPTER_RST_MS * 1000000 / `MCLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  // Processor bus
  input  wire logic [15:0]      busAddr,
  input  wire logic             busRw,
  input  wire logic             busCycleValid,
  input  wire logic [7:0]       busDataIn,
  output logic [7:0]            busDataOut,
  output logic                  busDataOe,
  output logic                  busClkE,
  output logic                  busClkQ,
  // Memory and peripheral selects
  output logic [1:0]            romSel_n,
  output logic [1:0]            ramSel_n,
  output logic                  nvSel_n,
  output logic                  pioSel_n,
  output logic                  tlaChipEnable_n,
  output logic [2:0]            adapterRegSelect,
  output logic [12:0]           memAddr,
  output logic                  memRead_n,
  output logic                  memWrite_n,
  output logic                  adapterReset_n,
  // Display latches and tick divider
  output logic [3:0][7:0]       displaySegments,
  output logic                  tickCounterClear
);

  ////////////////////////////////////////////////////////////////////////////////////////
  // Timing constants
  localparam logic [5:0]  BUS_PERIOD  = 6'(`BUS_PERIOD_NS / `MCLK_PERIOD_NS);
  localparam logic [5:0]  QUARTER     = 6'(`BUS_PERIOD_NS / `MCLK_PERIOD_NS / 4);
  localparam logic [5:0]  Q_RISE      = QUARTER;
  localparam logic [5:0]  E_RISE      = 6'(2 * QUARTER);
  localparam logic [5:0]  Q_FALL      = 6'(3 * QUARTER);
  localparam logic [5:0]  LAST_PHASE  = 6'(BUS_PERIOD - 6'h01);
  localparam logic [3:0]  MULT_CYCLES = 4'(`MULT_TIME_NS / `MCLK_PERIOD_NS);
  localparam logic [26:0] RST_LAST    = 27'(ADAPTER_RST_CYCLES - 1);
  localparam int          MULT_WAIT   = `MULT_TIME_NS / `MCLK_PERIOD_NS + 2;

  typedef struct packed {
    logic [5:0]                 phase;
    logic                       clkE;
    logic                       clkQ;
    logic                       active;
    logic                       rw;
    mpu_bridge_pkg::region_t    region;
    logic [12:0]                addrLow;
    logic [7:0]                 dataOut;
    logic                       dataOe;
    logic [7:0]                 holdByte;
    logic [7:0]                 lowByte;
    logic [3:0][7:0]            disp;
    logic [15:0]                operand;
    logic                       opAClk;
    logic                       opBClk;
    logic                       prodClk;
    logic                       aLoaded;
    logic                       bLoaded;
    logic [3:0]                 multCount;
    logic                       tickClr;
    logic [26:0]                rstCount;
    logic                       rstDone;
  } bridge_state_t;

  bridge_state_t               s;
  bridge_state_t               next_s;
  mpu_bridge_pkg::region_t     decoded;
  logic                        closeCycle;
  logic                        readCapture;
  logic                        productRead;
  logic [1:0]                  dispIndex;

  product_path_if pp ();

  ////////////////////////////////////////////////////////////////////////////////////////
  // Decoder and multiplier
  address_decoder address_decoder_i (
    .addr   (busAddr),
    .region (decoded)
  );

  multiplier_core multiplier_core_i (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .pp      (pp.core)
  );

  assign closeCycle  = s.active && (s.phase == LAST_PHASE);
  assign readCapture = s.active && s.rw && (s.phase == 6'(E_RISE + 6'h01));
  assign productRead = s.active && s.rw
                       && (s.region == mpu_bridge_pkg::REGION_MULTA
                           || s.region == mpu_bridge_pkg::REGION_MULTB);
  assign dispIndex   = {s.region == mpu_bridge_pkg::REGION_DISPB, s.addrLow[0]};

  ////////////////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    next_s = s;
    next_s.opAClk   = 1'b0;
    next_s.opBClk   = 1'b0;
    next_s.prodClk  = 1'b0;
    next_s.tickClr  = 1'b0;
    next_s.phase    = (s.phase == LAST_PHASE) ? 6'h00 : 6'(s.phase + 6'h01);
    next_s.clkQ     = (next_s.phase >= Q_RISE) && (next_s.phase < Q_FALL);
    next_s.clkE     = (next_s.phase >= E_RISE);

    // Access opens as E rises; address and direction are taken here
    if (s.phase == 6'(E_RISE - 6'h01))
    begin
      next_s.active  = busCycleValid;
      next_s.rw      = busRw;
      next_s.region  = busCycleValid ? decoded : mpu_bridge_pkg::REGION_NONE;
      next_s.addrLow = busAddr[12:0];
    end

    // Read data settles one cycle after E rises
    if (readCapture)
    begin
      case (s.region)
        mpu_bridge_pkg::REGION_MULTA,
        mpu_bridge_pkg::REGION_MULTB:
        begin
          next_s.dataOut = pp.productPort[15:8];
          next_s.lowByte = pp.productPort[7:0];
          next_s.dataOe  = 1'b1;
        end
        mpu_bridge_pkg::REGION_AUX:
        begin
          next_s.dataOut = s.lowByte;
          next_s.dataOe  = 1'b1;
        end
        default:
        begin
          next_s.dataOe = 1'b0;
        end
      endcase
    end

    // Writes take data as E falls
    if (closeCycle)
    begin
      next_s.active = 1'b0;
      next_s.dataOe = 1'b0;
      next_s.region = mpu_bridge_pkg::REGION_NONE;
      if (!s.rw)
      begin
        case (s.region)
          mpu_bridge_pkg::REGION_MULTA:
          begin
            next_s.operand = {s.holdByte, busDataIn};
            next_s.opAClk  = 1'b1;
            next_s.aLoaded = 1'b1;
          end
          mpu_bridge_pkg::REGION_MULTB:
          begin
            next_s.operand = {s.holdByte, busDataIn};
            next_s.opBClk  = 1'b1;
            next_s.bLoaded = 1'b1;
          end
          mpu_bridge_pkg::REGION_AUX:
            next_s.holdByte = busDataIn;
          mpu_bridge_pkg::REGION_DISPA,
          mpu_bridge_pkg::REGION_DISPB:
            next_s.disp[dispIndex] = busDataIn;
          mpu_bridge_pkg::REGION_TICK:
            next_s.tickClr = 1'b1;
          default:
            next_s.tickClr = 1'b0;
        endcase
      end
    end

    // Product strobes fire once both operands are in and the array has settled
    if (s.multCount != 4'h0)
    begin
      next_s.multCount = 4'(s.multCount - 4'h1);
      if (s.multCount == 4'h1)
      begin
        next_s.prodClk = 1'b1;
        next_s.aLoaded = next_s.opAClk;
        next_s.bLoaded = next_s.opBClk;
      end
    end
    else if (s.aLoaded && s.bLoaded && !s.opAClk && !s.opBClk)
    begin
      next_s.multCount = MULT_CYCLES;
    end

    // Adapter reset release after power-up
    if (!s.rstDone)
    begin
      next_s.rstCount = 27'(s.rstCount + 27'h1);
      next_s.rstDone  = (s.rstCount == RST_LAST);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // Multiplier control
  assign pp.operandARegClock    = s.opAClk;
  assign pp.operandBRegClock    = s.opBClk;
  assign pp.upperProductClock   = s.prodClk;
  assign pp.lowerProductClock   = s.prodClk;
  assign pp.operandWord         = s.operand;
  assign pp.productHalfSelect   = (s.region == mpu_bridge_pkg::REGION_MULTB);
  assign pp.productPortEnable_n = ~productRead;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign busDataOut       = s.dataOut;
  assign busDataOe        = s.dataOe && (pp.productPortOe || !productRead);
  assign busClkE          = s.clkE;
  assign busClkQ          = s.clkQ;
  assign romSel_n[0]      = ~(s.region == mpu_bridge_pkg::REGION_ROM0);
  assign romSel_n[1]      = ~(s.region == mpu_bridge_pkg::REGION_ROM1);
  assign ramSel_n[0]      = ~(s.region == mpu_bridge_pkg::REGION_RAM0);
  assign ramSel_n[1]      = ~(s.region == mpu_bridge_pkg::REGION_RAM1);
  assign nvSel_n          = ~(s.region == mpu_bridge_pkg::REGION_NVS);
  assign pioSel_n         = ~(s.region == mpu_bridge_pkg::REGION_PIO);
  assign tlaChipEnable_n  = ~(s.region == mpu_bridge_pkg::REGION_TLA);
  assign adapterRegSelect = s.addrLow[2:0];
  assign memAddr          = s.addrLow;
  assign memRead_n        = ~(s.active && s.rw);
  assign memWrite_n       = ~(s.active && !s.rw);
  assign adapterReset_n   = s.rstDone;
  assign displaySegments  = s.disp;
  assign tickCounterClear = s.tickClr;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_nvs_select;
    @(posedge mclk) disable iff (sys_rst)
    (s.phase == 6'(E_RISE - 6'h01) && busCycleValid
     && busAddr >= `ADDR_NVS && busAddr <= `ADDR_NVS_LAST) |=> !nvSel_n && ramSel_n == 2'h3;
  endproperty
  a_nvs_select: assert property (p_nvs_select)
    else $error("nonvolatile store not selected");

  property p_tla_select;
    @(posedge mclk) disable iff (sys_rst)
    (s.phase == 6'(E_RISE - 6'h01) && busCycleValid
     && busAddr >= `ADDR_TLA && busAddr <= `ADDR_TLA_LAST)
      |=> !tlaChipEnable_n && {13'h0000, adapterRegSelect} == ($past(busAddr) & 16'h0007);
  endproperty
  a_tla_select: assert property (p_tla_select)
    else $error("adapter enable or register select wrong");

  property p_one_select;
    @(posedge mclk) disable iff (sys_rst)
    $onehot0({~romSel_n, ~ramSel_n, ~nvSel_n, ~pioSel_n, ~tlaChipEnable_n, busDataOe});
  endproperty
  a_one_select: assert property (p_one_select)
    else $error("more than one device selected");

  property p_operand_a_load;
    @(posedge mclk) disable iff (sys_rst)
    (closeCycle && !s.rw && s.region == mpu_bridge_pkg::REGION_MULTA)
      |=> pp.operandARegClock && pp.operandWord == {$past(s.holdByte), $past(busDataIn)}
          ##1 multiplier_core_i.s.multiplicand == $past(pp.operandWord);
  endproperty
  a_operand_a_load: assert property (p_operand_a_load)
    else $error("multiplicand not loaded from holding latch and bus byte");

  property p_product_strobe;
    @(posedge mclk) disable iff (sys_rst)
    (s.opBClk && s.aLoaded) |-> ##[1:MULT_WAIT] pp.upperProductClock && pp.lowerProductClock;
  endproperty
  a_product_strobe: assert property (p_product_strobe)
    else $error("product strobes late");

  property p_product_read_enable;
    @(posedge mclk) disable iff (sys_rst)
    (s.active && s.rw && s.region == mpu_bridge_pkg::REGION_MULTA)
      |-> !pp.productPortEnable_n && !pp.productHalfSelect && pp.productPortOe;
  endproperty
  a_product_read_enable: assert property (p_product_read_enable)
    else $error("product port not enabled for high word read");

  property p_low_byte_latch;
    @(posedge mclk) disable iff (sys_rst)
    (readCapture && productRead)
      |=> {busDataOut, s.lowByte} == $past(pp.productPort);
  endproperty
  a_low_byte_latch: assert property (p_low_byte_latch)
    else $error("product bytes not captured");

  property p_tick_pulse;
    @(posedge mclk) disable iff (sys_rst)
    (closeCycle && !s.rw && s.region == mpu_bridge_pkg::REGION_TICK)
      |=> tickCounterClear ##1 !tickCounterClear;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse)
    else $error("tick clear not a single pulse");

  property p_adapter_reset;
    @(posedge mclk) disable iff (sys_rst)
    $rose(adapterReset_n) |-> $past(s.rstCount) == RST_LAST;
  endproperty
  a_adapter_reset: assert property (p_adapter_reset)
    else $error("adapter reset released at wrong count");

  property p_phase_quadrature;
    @(posedge mclk) disable iff (sys_rst)
    $rose(busClkQ) |-> ##15 $rose(busClkE);
  endproperty
  a_phase_quadrature: assert property (p_phase_quadrature)
    else $error("E does not follow Q by a quarter period");

endmodule // mpu_decode_multiplier_bridge

// ---- include/mpu_bridge_consts.svh ----
/*
  Address map, clock figures and timing constants for the processor bus bridge.
  Assumes an 8-bit processor bus with 16 address lines and a 125 MHz system clock.
*/
`ifndef MPU_BRIDGE_CONSTS_SVH
`define MPU_BRIDGE_CONSTS_SVH

`define MCLK_PERIOD_NS   8
`define BUS_PERIOD_NS    500
`define MULT_TIME_NS     75
`define ADAPTER_RST_MS   690

`define ADDR_MULT_A      16'h0000
`define ADDR_MULT_B      16'h0002
`define ADDR_DISP_A      16'h1000
`define ADDR_DISP_A_LAST 16'h1001
`define ADDR_DISP_B      16'h1040
`define ADDR_DISP_B_LAST 16'h1041
`define ADDR_AUX         16'h1080
`define ADDR_TICK_CLEAR  16'h1081
`define ADDR_TLA         16'h1100
`define ADDR_TLA_LAST    16'h1107
`define ADDR_PIO         16'h1200
`define ADDR_PIO_LAST    16'h120F
`define ADDR_NVS         16'h1400
`define ADDR_NVS_LAST    16'h17FF
`define ADDR_RAM0        16'h2000
`define ADDR_RAM0_LAST   16'h3FFF
`define ADDR_RAM1        16'h4000
`define ADDR_RAM1_LAST   16'h5FFF
`define ADDR_ROM0        16'h6000
`define ADDR_ROM1        16'hC000

`endif

// ---- include/mpu_bridge_pkg.sv ----
/*
  Types shared by the bridge, its address decoder and the multiplier core.
  Assumes the constants header is compiled alongside.
*/
package mpu_bridge_pkg;

  typedef enum logic [3:0] {
    REGION_NONE  = 4'h0,
    REGION_MULTA = 4'h1,
    REGION_MULTB = 4'h2,
    REGION_DISPA = 4'h3,
    REGION_DISPB = 4'h4,
    REGION_AUX   = 4'h5,
    REGION_TICK  = 4'h6,
    REGION_TLA   = 4'h7,
    REGION_PIO   = 4'h8,
    REGION_NVS   = 4'h9,
    REGION_RAM0  = 4'hA,
    REGION_RAM1  = 4'hB,
    REGION_ROM0  = 4'hC,
    REGION_ROM1  = 4'hD
  } region_t;

  typedef struct packed {
    logic [15:0] multiplicand;
    logic [15:0] multiplier;
    logic [15:0] upperWord;
    logic [15:0] lowerWord;
  } mult_state_t;

endpackage

// ---- include/product_path_if.sv ----
/*
  Signals between the bridge control logic and the 16x16 multiplier core.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface product_path_if;
  logic        operandARegClock;
  logic        operandBRegClock;
  logic        upperProductClock;
  logic        lowerProductClock;
  logic [15:0] operandWord;
  logic        productHalfSelect;
  logic        productPortEnable_n;
  logic [15:0] productPort;
  logic        productPortOe;

  modport ctrl (
    output operandARegClock, operandBRegClock, upperProductClock, lowerProductClock,
    output operandWord, productHalfSelect, productPortEnable_n,
    input  productPort, productPortOe
  );
  modport core (
    input  operandARegClock, operandBRegClock, upperProductClock, lowerProductClock,
    input  operandWord, productHalfSelect, productPortEnable_n,
    output productPort, productPortOe
  );
endinterface

// ---- rtl/address_decoder.sv ----
/*
  Full 64K address decoder: maps one bus address to exactly one region.
  Assumes the caller qualifies the result with a valid bus cycle.
*/
`timescale 1ns/1ps
`include "mpu_bridge_consts.svh"
module address_decoder (
  // Address in
  input  wire logic [15:0]            addr,
  // Decoded region
  output mpu_bridge_pkg::region_t     region
);
  always_comb
  begin
    region = mpu_bridge_pkg::REGION_NONE;
    if (addr == `ADDR_MULT_A)
      region = mpu_bridge_pkg::REGION_MULTA;
    else if (addr == `ADDR_MULT_B)
      region = mpu_bridge_pkg::REGION_MULTB;
    else if (addr >= `ADDR_DISP_A && addr <= `ADDR_DISP_A_LAST)
      region = mpu_bridge_pkg::REGION_DISPA;
    else if (addr >= `ADDR_DISP_B && addr <= `ADDR_DISP_B_LAST)
      region = mpu_bridge_pkg::REGION_DISPB;
    else if (addr == `ADDR_AUX)
      region = mpu_bridge_pkg::REGION_AUX;
    else if (addr == `ADDR_TICK_CLEAR)
      region = mpu_bridge_pkg::REGION_TICK;
    else if (addr >= `ADDR_TLA && addr <= `ADDR_TLA_LAST)
      region = mpu_bridge_pkg::REGION_TLA;
    else if (addr >= `ADDR_PIO && addr <= `ADDR_PIO_LAST)
      region = mpu_bridge_pkg::REGION_PIO;
    else if (addr >= `ADDR_NVS && addr <= `ADDR_NVS_LAST)
      region = mpu_bridge_pkg::REGION_NVS;
    else if (addr >= `ADDR_RAM0 && addr <= `ADDR_RAM0_LAST)
      region = mpu_bridge_pkg::REGION_RAM0;
    else if (addr >= `ADDR_RAM1 && addr <= `ADDR_RAM1_LAST)
      region = mpu_bridge_pkg::REGION_RAM1;
    else if (addr >= `ADDR_ROM1)
      region = mpu_bridge_pkg::REGION_ROM1;
    else if (addr >= `ADDR_ROM0)
      region = mpu_bridge_pkg::REGION_ROM0;
  end
endmodule // address_decoder

// ---- rtl/multiplier_core.sv ----
/*
  16x16 multiplier with separately clocked operand and product registers.
  Assumes the load strobes are one-cycle pulses on the system clock.
*/
`timescale 1ns/1ps
module multiplier_core (
  // Clock and reset
  input  wire logic  mclk,
  input  wire logic  sys_rst,
  // Bridge side
  product_path_if.core pp
);
  mpu_bridge_pkg::mult_state_t s;
  mpu_bridge_pkg::mult_state_t next_s;
  logic [31:0]                 product;

  assign product = s.multiplicand * s.multiplier;

  always_comb
  begin
    next_s = s;
    if (pp.operandARegClock)
      next_s.multiplicand = pp.operandWord;
    if (pp.operandBRegClock)
      next_s.multiplier = pp.operandWord;
    if (pp.upperProductClock)
      next_s.upperWord = product[31:16];
    if (pp.lowerProductClock)
      next_s.lowerWord = product[15:0];
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign pp.productPort   = pp.productHalfSelect ? s.lowerWord : s.upperWord;
  assign pp.productPortOe = ~pp.productPortEnable_n;
endmodule // multiplier_core

// ---- tb/bus_master_model.sv ----
/*
  Processor bus master model: one access per phase-clock period.
  Assumes the bridge generates busClkE and samples the bus inside that period.
*/
`timescale 1ns/1ps
module bus_master_model (
  // Clock and phase clock
  input  wire logic mclk,
  input  wire logic busClkE,
  // Bus request
  output logic [15:0] busAddr,
  output logic        busRw,
  output logic        busCycleValid,
  output logic [7:0]  busDataIn
);
  event sampled;
  initial
  begin
    busAddr = 16'hFFFF;
    busRw = 1'b1;
    busCycleValid = 1'b0;
    busDataIn = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Present while E is low, hold through the whole E-high phase
  task automatic access(input logic [15:0] a, input logic rw, input logic [7:0] d);
    @(negedge mclk);
    while (busClkE) @(negedge mclk);
    busAddr = a;
    busRw = rw;
    busCycleValid = 1'b1;
    busDataIn = d;
    while (!busClkE) @(negedge mclk);
    repeat (3) @(negedge mclk);
    ->sampled;
    while (busClkE) @(negedge mclk);
    // Released lines show the inverse, not a stale copy
    busCycleValid = 1'b0;
    busAddr = ~a;
    busDataIn = ~d;
  endtask
endmodule // bus_master_model

// ---- tb/mpu_decode_multiplier_bridge_tb.sv ----
/*
  Self-checking bench for the bus bridge.
  Assumes the bus master model drives all processor bus inputs.
*/
`timescale 1ns/1ps
module mpu_decode_multiplier_bridge_tb;
  logic            mclk;
  logic            sys_rst;
  logic [15:0]     busAddr;
  logic            busRw;
  logic            busCycleValid;
  logic [7:0]      busDataIn;
  logic [7:0]      busDataOut;
  logic            busDataOe;
  logic            busClkE;
  logic            busClkQ;
  logic            memWrite_n;
  logic [1:0]      romSel_n;
  logic [1:0]      ramSel_n;
  logic            nvSel_n;
  logic            pioSel_n;
  logic            tlaChipEnable_n;
  logic [2:0]      adapterRegSelect;
  logic [12:0]     memAddr;
  logic            memRead_n;
  logic            adapterReset_n;
  logic [3:0][7:0] displaySegments;
  logic            tickCounterClear;
  int              miscompares = 0;
  int              checks = 0;
  int              ticks = 0;
  mpu_decode_multiplier_bridge #(.ADAPTER_RST_CYCLES(20)) mpu_decode_multiplier_bridge_i (
    .mclk, .sys_rst, .busAddr, .busRw, .busCycleValid, .busDataIn, .busDataOut, .busDataOe,
    .busClkE, .busClkQ, .romSel_n, .ramSel_n, .nvSel_n, .pioSel_n, .tlaChipEnable_n,
    .adapterRegSelect, .memAddr, .memRead_n, .memWrite_n, .adapterReset_n,
    .displaySegments, .tickCounterClear);
  bus_master_model bus_master_model_i (.mclk, .busClkE, .busAddr, .busRw, .busCycleValid,
    .busDataIn);
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(negedge mclk) if (tickCounterClear === 1'b1) ticks++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_master_model_i.access(a, 1'b0, d);
  endtask
  // Read while snapshotting data and the decode outputs mid-access
  task automatic rd(input logic [15:0] a, output logic [7:0] r, output logic [24:0] s);
    fork
      bus_master_model_i.access(a, 1'b1, 8'h00);
      begin
        @(bus_master_model_i.sampled);
        r = busDataOut;
        s = {busDataOe, romSel_n, ramSel_n, nvSel_n, pioSel_n, tlaChipEnable_n, memRead_n,
             adapterRegSelect, memAddr};
      end
    join
  endtask
  // Write while snapshotting phase clocks, strobes and memory selects mid-access
  task automatic wrs(input logic [15:0] a, input logic [7:0] d, output logic [7:0] s);
    fork
      bus_master_model_i.access(a, 1'b0, d);
      begin
        @(bus_master_model_i.sampled);
        s = {busClkE, busClkQ, memWrite_n, memRead_n, ramSel_n, romSel_n};
      end
    join
  endtask
  // {romSel_n[1:0], ramSel_n[1:0], nvSel_n, pioSel_n, tlaChipEnable_n}
  function automatic logic [6:0] expSel(input logic [15:0] a);
    expSel = 7'h7F;
    if (a >= 16'hC000) expSel[6] = 1'b0;
    else if (a >= 16'h6000) expSel[5] = 1'b0;
    else if (a >= 16'h4000) expSel[4] = 1'b0;
    else if (a >= 16'h2000) expSel[3] = 1'b0;
    else if (a >= 16'h1400 && a <= 16'h17FF) expSel[2] = 1'b0;
    else if (a >= 16'h1200 && a <= 16'h120F) expSel[1] = 1'b0;
    else if (a >= 16'h1100 && a <= 16'h1107) expSel[0] = 1'b0;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic decode_map;
    logic [15:0] tbl [20] = '{16'h0004, 16'h1100, 16'h1105, 16'h1107, 16'h1108, 16'h120F,
      16'h1210, 16'h13FF, 16'h1400, 16'h17FF, 16'h1800, 16'h1FFF, 16'h2000, 16'h3FFF,
      16'h4000, 16'h5FFF, 16'h6000, 16'hBFFF, 16'hC000, 16'hFFFF};
    logic [7:0]  r;
    logic [24:0] s;
    foreach (tbl[i])
    begin
      rd(tbl[i], r, s);
      chk(s, {1'b0, expSel(tbl[i]), 1'b0, tbl[i][2:0], tbl[i][12:0]});
    end
  endtask
  task automatic multiply(input logic [15:0] a, input logic [15:0] b);
    logic [31:0] p;
    logic [7:0]  r;
    logic [24:0] s;
    p = {16'h0000, a} * {16'h0000, b};
    wr(16'h1080, a[15:8]);
    wr(16'h0000, a[7:0]);
    wr(16'h1080, b[15:8]);
    wr(16'h0002, b[7:0]);
    rd(16'h0000, r, s);
    chk({s[24], r}, {1'b1, p[31:24]});
    rd(16'h1080, r, s);
    chk({s[24], r}, {1'b1, p[23:16]});
    rd(16'h0002, r, s);
    chk({s[24], r}, {1'b1, p[15:8]});
    rd(16'h1080, r, s);
    chk({s[24], r}, {1'b1, p[7:0]});
  endtask
  task automatic display_and_tick;
    logic [7:0]  r;
    logic [24:0] s;
    int          t0;
    logic [7:0]  w;
    wrs(16'h2000, 8'h5A, w);
    chk(w, 8'hDB);
    wrs(16'hC000, 8'hA5, w);
    chk(w, 8'hDD);
    wr(16'h1000, 8'h11);
    wr(16'h1001, 8'h22);
    wr(16'h1040, 8'h33);
    wr(16'h1041, 8'h44);
    wr(16'h1042, 8'h99);
    chk(displaySegments, 32'h44332211);
    rd(16'h1000, r, s);
    chk(s[24], 1'b0);
    t0 = ticks;
    wr(16'h1081, 8'hA5);
    repeat (3) @(negedge mclk);
    chk(ticks - t0, 1);
  endtask
  initial
  begin
    sys_rst = 1'b1;
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    @(negedge mclk);
    chk({adapterReset_n, displaySegments}, 33'h0);
    repeat (24) @(negedge mclk);
    chk(adapterReset_n, 1'b1);
    decode_map();
    multiply(16'h1234, 16'hABCD);
    multiply(16'hFFFF, 16'hFFFF);
    display_and_tick();
    end_of_test();
  end
  initial
  begin
    #200000;
    miscompares++;
    end_of_test();
  end
endmodule // mpu_decode_multiplier_bridge_tb
